// File: hw/axcfg_pending_cnt.sv
// Purpose: up/down count of outstanding link transfers
// Assumes: the link never retires more than it issued
// Notes: wraps silently; depth is far beyond normal traffic
`timescale 1ns/10ps
`default_nettype none
module axcfg_pending_cnt
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // events
  input wire logic up,
  input wire logic dn,
  // count
  output logic [axcfg_pkg::CNT_W-1:0] count
);

  // ==========================================================
  // counter
  logic [axcfg_pkg::CNT_W-1:0] count_reg;
  logic [axcfg_pkg::CNT_W-1:0] count_next;

  // both at once leave the count unchanged
  always_comb
  begin
    count_next = count_reg;
    if (!reset_n)
      count_next = '0;
    else if (up && !dn)
      count_next = count_reg + 1'b1;
    else if (dn && !up)
      count_next = count_reg - 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    count_reg <= count_next;
  end

  assign count = count_reg;

endmodule : axcfg_pending_cnt
`default_nettype wire

// File: hw/axcfg_pkg.sv
// Purpose: shared constants and types for the link configuration checks
// Assumes: 32-bit monitored data and address, 4-bit ids and user fields
// Notes: the violation vector keeps its shared bit numbering 94..107
package axcfg_pkg;

  // ==========================================================
  // monitored link carrier
  typedef struct packed
  {
    logic valid;
    logic ready;
    logic [31:0] addr;
    logic [1:0] burst;
    logic [3:0] cache;
    logic [3:0] id;
    logic [7:0] len;
    logic lock;
    logic [2:0] prot;
    logic [3:0] qos;
    logic [2:0] size;
    logic [3:0] user;
    logic [3:0] region;
  } axcfg_addr_t;

  typedef struct packed
  {
    axcfg_addr_t ar;
    axcfg_addr_t aw;
    logic wvalid;
    logic wready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wlast;
    logic bvalid;
    logic bready;
    logic [1:0] bresp;
    logic rvalid;
    logic rready;
    logic [1:0] rresp;
    logic rlast;
  } axcfg_link_t;

  // ==========================================================
  // violation vector slice and bit numbers
  typedef logic [107:94] axcfg_vec_t;
  localparam int BIT_BREADY_RST = 94;
  localparam int BIT_ARREADY_RST = 95;
  localparam int BIT_RREADY_RST = 96;
  localparam int BIT_RD_WAIT = 97;
  localparam int BIT_WR_WAIT = 98;
  localparam int BIT_LAST_ADDR = 99;
  localparam int BIT_RESP_WAIT = 100;
  localparam int BIT_RST_WIDTH = 101;
  localparam int BIT_NO_STRB_ALIGN = 102;
  localparam int BIT_NARROW_SIZE = 103;
  localparam int BIT_RD_SLVERR = 104;
  localparam int BIT_RD_DECERR = 105;
  localparam int BIT_WR_SLVERR = 106;
  localparam int BIT_WR_DECERR = 107;
  // bits that stay alive in the reduced configuration
  localparam axcfg_vec_t LIGHT_KEEP = 14'h0378;

  // ==========================================================
  // link encodings and limits
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [2:0] FULL_SIZE = 3'h2;
  localparam int ALIGN_W = 2;
  localparam int RST_MIN_CYCLES = 16;
  localparam int LIMIT_W = 16;
  localparam logic [15:0] LIMIT_RESET = 16'h0100;
  localparam int NUM_TIMERS = 4;
  localparam int NUM_CNT = 3;
  localparam int CNT_W = 8;

  // ==========================================================
  // register port map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RD_WAIT = 8'h04;
  localparam logic [7:0] REG_WR_WAIT = 8'h08;
  localparam logic [7:0] REG_LAST_ADDR = 8'h0C;
  localparam logic [7:0] REG_RESP_WAIT = 8'h10;
  localparam logic [7:0] REG_VECTOR = 8'h14;
  localparam logic [7:0] REG_SNAPSHOT = 8'h18;
  localparam logic [7:0] REG_FLAG = 8'h1C;
  localparam int CTRL_ERR_CHK = 0;
  localparam int CTRL_LIGHT = 1;
  localparam int CTRL_HAS_STRB = 2;
  localparam int CTRL_NARROW = 3;
  localparam int CTRL_LITE = 4;
  localparam int CTRL_AXI3 = 5;
  localparam logic [5:0] CTRL_RESET = 6'h04;

endpackage : axcfg_pkg

// File: hw/axcfg_timing_checks.sv
// Purpose: configuration, wait-limit and reset checks on a monitored link
// Assumes: link and register port share clk_sys; monitor only listens
// Notes: violation bits are sticky until the link reset
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module axcfg_timing_checks
(
  // clock and link reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // monitored link
  input wire axcfg_pkg::axcfg_link_t link,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // violation outputs
  output axcfg_pkg::axcfg_vec_t violation_vector,
  output logic any_violation_flag
);

  // ==========================================================
  // handshakes
  logic ar_hs;
  logic aw_hs;
  logic w_hs;
  logic wl_hs;
  logic b_hs;
  logic r_hs;
  assign ar_hs = link.ar.valid && link.ar.ready;
  assign aw_hs = link.aw.valid && link.aw.ready;
  assign w_hs = link.wvalid && link.wready;
  assign b_hs = link.bvalid && link.bready;
  assign r_hs = link.rvalid && link.rready;

  // ==========================================================
  // configuration registers
  logic [5:0] ctrl_reg;
  logic [5:0] ctrl_next;
  logic [axcfg_pkg::LIMIT_W-1:0] limit_reg [axcfg_pkg::NUM_TIMERS];
  logic [axcfg_pkg::LIMIT_W-1:0] limit_next [axcfg_pkg::NUM_TIMERS];
  logic err_chk;
  logic light;
  logic has_strb;
  logic narrow;
  logic lite;
  assign err_chk = ctrl_reg[axcfg_pkg::CTRL_ERR_CHK];
  assign light = ctrl_reg[axcfg_pkg::CTRL_LIGHT];
  assign has_strb = ctrl_reg[axcfg_pkg::CTRL_HAS_STRB];
  assign narrow = ctrl_reg[axcfg_pkg::CTRL_NARROW];
  assign lite = ctrl_reg[axcfg_pkg::CTRL_LITE];
  // a lite write data beat always ends its burst
  assign wl_hs = w_hs && (link.wlast || lite);

  // software writes; limits index in timer order
  always_comb
  begin
    ctrl_next = ctrl_reg;
    limit_next = limit_reg;
    if (!reset_n)
    begin
      ctrl_next = axcfg_pkg::CTRL_RESET;
      for (int i = 0; i < axcfg_pkg::NUM_TIMERS; i++)
        limit_next[i] = axcfg_pkg::LIMIT_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        axcfg_pkg::REG_CTRL: ctrl_next = reg_wdata[5:0];
        axcfg_pkg::REG_RD_WAIT: limit_next[0] = reg_wdata[15:0];
        axcfg_pkg::REG_WR_WAIT: limit_next[1] = reg_wdata[15:0];
        axcfg_pkg::REG_LAST_ADDR: limit_next[2] = reg_wdata[15:0];
        axcfg_pkg::REG_RESP_WAIT: limit_next[3] = reg_wdata[15:0];
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    ctrl_reg <= ctrl_next;
    limit_reg <= limit_next;
  end

  // ==========================================================
  // outstanding transfer counters: reads, aw-to-b, wlast-to-b
  logic [axcfg_pkg::CNT_W-1:0] pend [axcfg_pkg::NUM_CNT];
  logic [axcfg_pkg::NUM_CNT-1:0] pend_up;
  logic [axcfg_pkg::NUM_CNT-1:0] pend_dn;
  assign pend_up = {wl_hs, aw_hs, ar_hs};
  assign pend_dn = {b_hs, b_hs, r_hs && (link.rlast || lite)};

  generate
    for (genvar g = 0; g < axcfg_pkg::NUM_CNT; g++)
    begin : g_pend
      axcfg_pending_cnt u_pend
      (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .up(pend_up[g]),
        .dn(pend_dn[g]),
        .count(pend[g])
      );
    end
  endgenerate

  // ==========================================================
  // wait-limit timers: read data, write data, address, response
  logic [axcfg_pkg::NUM_TIMERS-1:0] t_active;
  logic [axcfg_pkg::NUM_TIMERS-1:0] t_restart;
  logic [axcfg_pkg::NUM_TIMERS-1:0] t_seen;
  logic [axcfg_pkg::NUM_TIMERS-1:0] t_out;

  always_comb
  begin
    t_active[0] = pend[0] != '0;
    t_restart[0] = ar_hs || r_hs;
    t_seen[0] = link.rvalid;
    t_active[1] = pend[1] > pend[2];
    t_restart[1] = aw_hs || w_hs;
    t_seen[1] = link.wvalid;
    t_active[2] = pend[2] > pend[1];
    t_restart[2] = wl_hs || aw_hs;
    t_seen[2] = link.aw.valid;
    t_active[3] = (pend[1] != '0) && (pend[2] != '0);
    t_restart[3] = aw_hs || wl_hs || b_hs;
    t_seen[3] = link.bvalid;
  end

  generate
    for (genvar g = 0; g < axcfg_pkg::NUM_TIMERS; g++)
    begin : g_timer
      axcfg_wait_timer u_timer
      (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .active(t_active[g]),
        .restart(t_restart[g]),
        .seen(t_seen[g]),
        .limit(limit_reg[g]),
        .timeout(t_out[g])
      );
    end
  endgenerate

  // ==========================================================
  // reset history: a shift line avoids a counter with no reset value
  logic [axcfg_pkg::RST_MIN_CYCLES-1:0] rst_hist_reg;
  logic [axcfg_pkg::RST_MIN_CYCLES-1:0] rst_hist_next;
  logic release_cyc;
  assign rst_hist_next = {rst_hist_reg[axcfg_pkg::RST_MIN_CYCLES-2:0],
                          reset_n};
  // first cycle with reset released
  assign release_cyc = reset_n && !rst_hist_reg[0];

  always_ff @(posedge clk_sys)
  begin
    rst_hist_reg <= rst_hist_next;
  end

  // ==========================================================
  // violation events
  axcfg_pkg::axcfg_vec_t ev;

  always_comb
  begin
    ev = '0;
    ev[axcfg_pkg::BIT_BREADY_RST] = release_cyc && link.bready;
    ev[axcfg_pkg::BIT_ARREADY_RST] = release_cyc && link.ar.ready;
    ev[axcfg_pkg::BIT_RREADY_RST] = release_cyc && link.rready;
    ev[axcfg_pkg::BIT_RD_WAIT] = t_out[0];
    ev[axcfg_pkg::BIT_WR_WAIT] = t_out[1];
    ev[axcfg_pkg::BIT_LAST_ADDR] = t_out[2];
    ev[axcfg_pkg::BIT_RESP_WAIT] = t_out[3];
    // any high sample in the last 16 means the low pulse was short
    ev[axcfg_pkg::BIT_RST_WIDTH] = release_cyc && (rst_hist_reg[
      axcfg_pkg::RST_MIN_CYCLES-1:1] != '0);
    ev[axcfg_pkg::BIT_NO_STRB_ALIGN] = !has_strb &&
      ((ar_hs && link.ar.addr[axcfg_pkg::ALIGN_W-1:0] != '0) ||
       (aw_hs && link.aw.addr[axcfg_pkg::ALIGN_W-1:0] != '0));
    ev[axcfg_pkg::BIT_NARROW_SIZE] = aw_hs && narrow && has_strb &&
      (link.aw.size < axcfg_pkg::FULL_SIZE);
    ev[axcfg_pkg::BIT_RD_SLVERR] = err_chk && r_hs &&
      (link.rresp == axcfg_pkg::RESP_SLVERR);
    ev[axcfg_pkg::BIT_RD_DECERR] = err_chk && r_hs &&
      (link.rresp == axcfg_pkg::RESP_DECERR);
    ev[axcfg_pkg::BIT_WR_SLVERR] = err_chk && b_hs &&
      (link.bresp == axcfg_pkg::RESP_SLVERR);
    ev[axcfg_pkg::BIT_WR_DECERR] = err_chk && b_hs &&
      (link.bresp == axcfg_pkg::RESP_DECERR);
  end

  // ==========================================================
  // sticky vector, summary flag and first-event snapshot
  axcfg_pkg::axcfg_vec_t vec_reg;
  axcfg_pkg::axcfg_vec_t vec_next;
  axcfg_pkg::axcfg_vec_t snap_reg;
  axcfg_pkg::axcfg_vec_t snap_next;
  axcfg_pkg::axcfg_vec_t en_mask;
  logic any_reg;
  logic any_next;
  assign en_mask = light ? axcfg_pkg::LIGHT_KEEP : '1;

  // reset clears every bit; a width fault is set in the release cycle after
  always_comb
  begin
    if (!reset_n)
      vec_next = '0;
    else
      vec_next = vec_reg | (ev & en_mask);
    any_next = vec_next != '0;
    snap_next = snap_reg;
    if (!reset_n)
      snap_next = '0;
    else if (!any_reg && any_next)
      snap_next = vec_next;
  end

  always_ff @(posedge clk_sys)
  begin
    vec_reg <= vec_next;
    any_reg <= any_next;
    snap_reg <= snap_next;
  end

  assign violation_vector = vec_reg;
  assign any_violation_flag = any_reg;

  // ==========================================================
  // register read data, valid only the cycle after the strobe
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (reset_n && reg_rd)
    begin
      case (reg_addr)
        axcfg_pkg::REG_CTRL: rdata_next = {26'h000_0000, ctrl_reg};
        axcfg_pkg::REG_RD_WAIT: rdata_next = {16'h0000, limit_reg[0]};
        axcfg_pkg::REG_WR_WAIT: rdata_next = {16'h0000, limit_reg[1]};
        axcfg_pkg::REG_LAST_ADDR: rdata_next = {16'h0000, limit_reg[2]};
        axcfg_pkg::REG_RESP_WAIT: rdata_next = {16'h0000, limit_reg[3]};
        axcfg_pkg::REG_VECTOR: rdata_next = {18'h0_0000, vec_reg};
        axcfg_pkg::REG_SNAPSHOT: rdata_next = {18'h0_0000, snap_reg};
        axcfg_pkg::REG_FLAG: rdata_next = {31'h0000_0000, any_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    rdata_reg <= rdata_next;
  end

  assign reg_rdata = rdata_reg;

  // ==========================================================
  // checks on the block's own behaviour
  sequence s_release;
    reset_n && !rst_hist_reg[0];
  endsequence

  sequence s_short_release;
    s_release ##0 (rst_hist_reg[15:1] != '0);
  endsequence

  chk_ready_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_release ##0 (link.bready && !light)
    |=> violation_vector[94] && any_violation_flag)
    else $error("ready after reset not flagged");

  chk_reset_width: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_short_release ##0 !light |=> violation_vector[101])
    else $error("short reset not flagged");

  chk_read_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (t_active[0] && !link.rvalid && !t_restart[0] && limit_reg[0] == 16'h0004)
      [*5] |=> violation_vector[97])
    else $error("read data wait not flagged");

  chk_resp_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(t_out[3]) |=> violation_vector[100])
    else $error("response wait not flagged");

  chk_align_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (ar_hs && !has_strb && link.ar.addr[1:0] != 2'h0)
    |=> violation_vector[102])
    else $error("misaligned address not flagged");

  chk_narrow_size: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (aw_hs && narrow && has_strb && link.aw.size < 3'h2)
    |=> violation_vector[103])
    else $error("narrow size not flagged");

  chk_rd_error: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (r_hs && link.rresp == 2'h3) |=>
      (violation_vector[105] == $past(err_chk && !light || vec_reg[105])))
    else $error("read decode error flag wrong");

  chk_wr_error: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (b_hs && link.bresp == 2'h2 && !err_chk && !vec_reg[106])
    |=> !violation_vector[106])
    else $error("write error set while disabled");

  chk_light_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (light && !vec_reg[94] && $past(reset_n)) |=> !violation_vector[94])
    else $error("reduced mode set a dropped bit");

  chk_snap_first: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(any_violation_flag) |-> (snap_reg == violation_vector) ##1
    $stable(snap_reg))
    else $error("snapshot not first value");

  // unknown-value messages; they never touch the vector
  chk_ar_known: assert property (@(posedge clk_sys) disable iff (!reset_n)
    link.ar.valid |-> !$isunknown({link.ar.addr, link.ar.prot}) &&
    (lite || !$isunknown({link.ar.burst, link.ar.cache, link.ar.id,
      link.ar.len, link.ar.lock, link.ar.qos, link.ar.size, link.ar.user}))
    && (lite || ctrl_reg[5] || !$isunknown(link.ar.region)))
    else $error("unknown read address field");

  chk_aw_known: assert property (@(posedge clk_sys) disable iff (!reset_n)
    link.aw.valid |-> !$isunknown({link.aw.addr, link.aw.prot}) &&
    (lite || !$isunknown({link.aw.burst, link.aw.cache, link.aw.id,
      link.aw.len, link.aw.lock, link.aw.qos, link.aw.size, link.aw.user}))
    && (lite || ctrl_reg[5] || !$isunknown(link.aw.region)))
    else $error("unknown write address field");

  chk_ctl_known: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !$isunknown({link.ar.valid, link.aw.valid, link.bready,
      link.rready}))
    else $error("unknown master control");

  chk_wlast_known: assert property (@(posedge clk_sys) disable iff (!reset_n)
    link.wvalid && !lite |-> !$isunknown(link.wlast))
    else $error("unknown write last");

  generate
    for (genvar l = 0; l < 4; l++)
    begin : g_lane
      chk_wdata_lane: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        link.wvalid && link.wstrb[l] |->
        !$isunknown(link.wdata[8*l +: 8]))
        else $error("unknown write data lane");
    end
  endgenerate

endmodule : axcfg_timing_checks
`default_nettype wire

// File: hw/axcfg_wait_timer.sv
// Purpose: cycle counter for one wait-limit check
// Assumes: limit of zero switches the check off
// Notes: timeout is a level while the limit is reached without valid
`timescale 1ns/10ps
`default_nettype none
module axcfg_wait_timer
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // qualifiers
  input wire logic active,
  input wire logic restart,
  input wire logic seen,
  input wire logic [axcfg_pkg::LIMIT_W-1:0] limit,
  // result
  output logic timeout
);

  // ==========================================================
  // counter
  logic [axcfg_pkg::LIMIT_W-1:0] count_reg;
  logic [axcfg_pkg::LIMIT_W-1:0] count_next;

  // restart on every qualifying transfer, hold once at the limit
  always_comb
  begin
    if (!reset_n || !active || restart || seen)
      count_next = '0;
    else if (count_reg < limit) // a lowered limit cannot be overrun
      count_next = count_reg + 1'b1;
    else
      count_next = count_reg;
  end

  always_ff @(posedge clk_sys)
  begin
    count_reg <= count_next;
  end

  // no valid by the limit while still waiting
  assign timeout = active && !restart && !seen && (limit != '0) &&
                   (count_reg >= limit);

  chk_count_cleared: assert property (@(posedge clk_sys)
    (!reset_n || !active || seen) |=> (count_reg == '0))
    else $error("wait counter not cleared");

endmodule : axcfg_wait_timer
`default_nettype wire

// File: test/axcfg_link_model.sv
// Purpose: behavioural master and slave on the monitored link
// Assumes: one hs call is one cycle of handshakes
// Notes: released address and data lines flip so stale values never pass
`timescale 1ns/10ps
`default_nettype none
module axcfg_link_model
(
  // clock
  input wire logic clk_sys,
  // driven link
  output var axcfg_pkg::axcfg_link_t link
);
  // when set, data beats go out without their last marker
  logic no_last = 1'b0;

  // ==========================================================
  // idle link: every field known, all ready low in reset
  initial
  begin
    link = '0;
  end

  // ready lines for the release cycle only (b, ar, r)
  task rdy(input logic [2:0] r);
    link.bready <= r[0];
    link.ar.ready <= r[1];
    link.rready <= r[2];
  endtask : rdy

  // ==========================================================
  // handshake on channels m = {r, b, w, aw, ar}
  task hs(input logic [4:0] m, input logic [1:0] rs,
    input logic [31:0] a, input logic [2:0] sz);
    @(posedge clk_sys);
    link.ar.valid <= m[0];
    link.ar.ready <= m[0];
    link.ar.addr <= a;
    link.aw.valid <= m[1];
    link.aw.ready <= m[1];
    link.aw.addr <= a;
    link.aw.size <= sz;
    link.wvalid <= m[2];
    link.wready <= m[2];
    link.wlast <= m[2] && !no_last;
    link.bvalid <= m[3];
    link.bready <= m[3];
    link.bresp <= rs;
    link.rvalid <= m[4];
    link.rready <= m[4];
    link.rresp <= rs;
    link.rlast <= m[4] && !no_last;
    @(posedge clk_sys);
    // release: handshakes drop, address and data flip
    link.ar.valid <= 1'b0;
    link.aw.valid <= 1'b0;
    link.wvalid <= 1'b0;
    link.wready <= 1'b0;
    link.bvalid <= 1'b0;
    link.rvalid <= 1'b0;
    link.aw.ready <= 1'b0;
    rdy(3'h0);
    link.ar.addr <= ~a;
    link.aw.addr <= ~a;
    link.wdata <= ~link.wdata;
  endtask : hs
endmodule : axcfg_link_model
`default_nettype wire

// File: test/test_axi_config_timing_checks.sv
// Purpose: self-checking bench for the link configuration checks
// Assumes: one clock, limits shortened to 4 through the register port
// Notes: every test starts from a fresh reset since bits are sticky
`timescale 1ns/10ps
`default_nettype none
module test_axi_config_timing_checks;
  // ==========================================================
  // stimulus and observation
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_val;
  axcfg_pkg::axcfg_link_t link;
  axcfg_pkg::axcfg_vec_t violation_vector;
  logic any_violation_flag;
  int err_count = 0;
  int num_checks = 0;

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  axcfg_timing_checks DUT
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .link(link),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .violation_vector(violation_vector),
    .any_violation_flag(any_violation_flag)
  );

  axcfg_link_model m
  (
    .clk_sys(clk_sys),
    .link(link)
  );

  // ==========================================================
  // shared tasks
  task complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  function automatic logic [31:0] bv(input int b);
    return 32'h0000_0001 << (b - 94);
  endfunction : bv

  task vec(input string n, input logic [31:0] e);
    rd(axcfg_pkg::REG_VECTOR);
    chk(n, e, rd_val);
  endtask : vec

  // low for n sampled edges; r raises ready in the release cycle
  task rst(input int n, input logic [2:0] r);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    reset_n <= 1'b1;
    m.rdy(r);
    @(posedge clk_sys);
    m.rdy(3'h0);
  endtask : rst

  // ==========================================================
  // scenarios
  task t_reset();
    rst(16, 3'h0);
    rd(axcfg_pkg::REG_CTRL);
    chk("ctrl", 32'h0000_0004, rd_val);
    rd(axcfg_pkg::REG_RD_WAIT);
    chk("limit", 32'h0000_0100, rd_val);
    rd(8'h20);
    chk("unmapped", 32'h0000_0000, rd_val);
    wr(axcfg_pkg::REG_VECTOR, 32'hFFFF_FFFF);
    vec("ro_vec", 32'h0000_0000);
    for (int b = 0; b < 3; b++)
    begin
      rst(16, 3'h1 << b);
      vec("rdy_rst", bv(94 + b));
    end
    rst(4, 3'h0);
    vec("short_rst", bv(101));
    rst(16, 3'h0);
    vec("full_rst", 32'h0000_0000);
    chk("flag_idle", 32'h0000_0000, {31'h0000_0000, any_violation_flag});
    $display("reset test done");
  endtask : t_reset

  // ar only, aw only, w last only, aw with w last
  task t_timer();
    logic [7:0] ra [4];
    logic [4:0] mk [4];
    ra = '{8'h04, 8'h08, 8'h0C, 8'h10};
    mk = '{5'h01, 5'h02, 5'h04, 5'h06};
    for (int i = 0; i < 4; i++)
    begin
      rst(16, 3'h0);
      wr(ra[i], 32'h0000_0004);
      m.hs(mk[i], 2'h0, 32'h0000_0000, 3'h2);
      repeat (4) @(posedge clk_sys);
      #1 chk("wait_early", 0, {18'h0, violation_vector});
      repeat (1) @(posedge clk_sys);
      #1 chk("wait_late", bv(97 + i), {18'h0, violation_vector});
    end
    // data beat with no last marker only ends a burst on a lite link
    m.no_last = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      rst(16, 3'h0);
      wr(axcfg_pkg::REG_CTRL, 32'h0000_0004 | (i << 4));
      wr(axcfg_pkg::REG_LAST_ADDR, 32'h0000_0004);
      m.hs(5'h04, 2'h0, 32'h0000_0000, 3'h2);
      repeat (5) @(posedge clk_sys);
      #1 chk("lite_last", i ? bv(99) : 0, {18'h0, violation_vector});
    end
    m.no_last = 1'b0;
    $display("wait test done");
  endtask : t_timer

  task t_resp();
    for (int i = 0; i < 4; i++)
    begin
      rst(16, 3'h0);
      wr(axcfg_pkg::REG_CTRL, 32'h0000_0005);
      m.hs(i < 2 ? 5'h01 : 5'h06, 2'h0, 32'h0000_0000, 3'h2);
      m.hs(i < 2 ? 5'h10 : 5'h08, 2'h2 + i[0], 32'h0000_0000, 3'h2);
      vec("err_resp", bv(104 + i));
    end
    rst(16, 3'h0);
    m.hs(5'h01, 2'h0, 32'h0000_0000, 3'h2);
    m.hs(5'h10, 2'h2, 32'h0000_0000, 3'h2);
    m.hs(5'h06, 2'h0, 32'h0000_0000, 3'h2);
    m.hs(5'h08, 2'h2, 32'h0000_0000, 3'h2);
    vec("resp_off", 32'h0000_0000);
    rst(16, 3'h0);
    wr(axcfg_pkg::REG_CTRL, 32'h0000_0003);
    m.hs(5'h01, 2'h0, 32'h0000_0002, 3'h2);
    m.hs(5'h10, 2'h3, 32'h0000_0000, 3'h2);
    vec("reduced", bv(102));
    $display("response test done");
  endtask : t_resp

  task t_align();
    rst(16, 3'h0);
    wr(axcfg_pkg::REG_CTRL, 32'h0000_0001);
    m.hs(5'h01, 2'h0, 32'h0000_0002, 3'h2);
    vec("misalign", bv(102));
    m.hs(5'h10, 2'h2, 32'h0000_0000, 3'h2);
    vec("two_bits", bv(102) | bv(104));
    rd(axcfg_pkg::REG_SNAPSHOT);
    chk("snapshot", bv(102), rd_val);
    rd(axcfg_pkg::REG_FLAG);
    chk("flag", 32'h0000_0001, rd_val);
    chk("flag_pin", 32'h0000_0001, {31'h0000_0000, any_violation_flag});
    rst(16, 3'h0);
    wr(axcfg_pkg::REG_CTRL, 32'h0000_000C);
    m.hs(5'h02, 2'h0, 32'h0000_0000, 3'h2);
    vec("full_size", 32'h0000_0000);
    m.hs(5'h02, 2'h0, 32'h0000_0000, 3'h1);
    vec("narrow", bv(103));
    $display("alignment test done");
  endtask : t_align

  // ==========================================================
  // main sequence and hang guard
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_timer();
    t_resp();
    t_align();
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    $display("[ERR] run exp done got hang");
    err_count++;
    complete_run();
  end
endmodule : test_axi_config_timing_checks
`default_nettype wire
